// file: src/pwmtg_top.sv
`timescale 1ns/1ns
module pwmtg_top #(
    parameter int HAS_ROUTING = 1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ext_gate,
    input wire logic i_lower_out,
    input wire logic i_pulse_gate,
    output logic [31:0] o_rdata,
    output logic o_pulse,
    output logic o_train
);
    generate
        if (HAS_ROUTING != 0 && HAS_ROUTING != 1)
            $error("HAS_ROUTING must be 0 or 1");
    endgenerate

    typedef struct packed {
        logic run;
        logic [4:0] chip;
        logic [1:0] chan;
        logic [2:0] pclk;
        logic [2:0] tclk;
        logic [1:0] tgate;
        logic [pwmtg_pkg::COUNT_W-1:0] div;
        logic [pwmtg_pkg::COUNT_W-1:0] low;
        logic [31:0] rdata;
        logic [pwmtg_pkg::NUM_SRC-1:0] ticks;
        logic [pwmtg_pkg::NUM_SRC-1:0][pwmtg_pkg::ACC_W-1:0] acc;
        logic [2:0] sync1;
        logic [2:0] sync2;
    } pwmtg_top_state_type;

    pwmtg_top_state_type state_reg;
    pwmtg_top_state_type state_next;
    pwmtg_chan_if train_if ();
    pwmtg_chan_if pulse_if ();
    logic [6:0] train_map;
    logic train_gate;

    function automatic logic pick_tick(input logic [pwmtg_pkg::NUM_SRC-1:0] ticks,
                                       input logic [2:0] code);
        if (code >= pwmtg_pkg::CLK_SEL_TEN_MEG && code <= pwmtg_pkg::CLK_SEL_ONE_KILO)
            return ticks[code - 3'h1];
        else
            return 1'b0;
    endfunction

    assign train_map = pwmtg_pkg::train_of(state_reg.chip, state_reg.chan);

    always_comb
    begin
        if (HAS_ROUTING == 0)
            train_gate = state_reg.sync2[0];
        else
        begin
            case (state_reg.tgate)
                pwmtg_pkg::GATE_FORCE_HIGH: train_gate = 1'b1;
                pwmtg_pkg::GATE_FORCE_LOW: train_gate = 1'b0;
                pwmtg_pkg::GATE_EXTERNAL_INPUT: train_gate = state_reg.sync2[0];
                pwmtg_pkg::GATE_INVERTED_LOWER_OUTPUT: train_gate = !state_reg.sync2[1];
                default: train_gate = 1'b1;
            endcase
        end
    end

    // Train channel: rate generator
    assign train_if.tick = pick_tick(state_reg.ticks, state_reg.tclk);
    assign train_if.gate = train_gate;
    assign train_if.oneshot = 1'b0;
    assign train_if.enable = 1'b1;
    assign train_if.load = state_reg.div;

    // Pulse channel: one-shot retriggered by the train output, or by the i_pulse_gate pin when HAS_ROUTING is 0
    assign pulse_if.tick = pick_tick(state_reg.ticks, state_reg.pclk);
    assign pulse_if.gate = (HAS_ROUTING != 0) ? train_if.out : state_reg.sync2[2];
    assign pulse_if.oneshot = 1'b1;
    assign pulse_if.enable = state_reg.run;
    assign pulse_if.load = state_reg.low;

    pwmtg_chan u_train (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .ch(train_if.chan)
    );

    pwmtg_chan u_pulse (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .ch(pulse_if.chan)
    );

    always_comb
    begin
        logic [pwmtg_pkg::ACC_W:0] sum;
        sum = '0;
        state_next = state_reg;
        state_next.sync1 = {i_pulse_gate, i_lower_out, i_ext_gate};
        state_next.sync2 = state_reg.sync1;
        // Fractional stepping keeps the average rate exact; only the 10 MHz ticks jitter, by one cycle
        for (int i = 0; i < pwmtg_pkg::NUM_SRC; i++)
        begin
            sum = {1'b0, state_reg.acc[i]} + {1'b0, pwmtg_pkg::source_rate(i)};
            if (sum >= {1'b0, pwmtg_pkg::SYS_CLK_HZ})
            begin
                sum = sum - {1'b0, pwmtg_pkg::SYS_CLK_HZ};
                state_next.ticks[i] = 1'b1;
            end
            else
                state_next.ticks[i] = 1'b0;
            state_next.acc[i] = sum[pwmtg_pkg::ACC_W-1:0];
        end
        if (i_wr)
        begin
            case (i_addr)
                pwmtg_pkg::OFS_CTRL:
                    state_next.run = i_wdata[pwmtg_pkg::CTRL_RUN_BIT];
                pwmtg_pkg::OFS_CONFIG:
                begin
                    // Invalid chip or channel values leave the old setting in place
                    if (i_wdata[pwmtg_pkg::CFG_CHIP_LSB +: 2] == 2'h0
                        && i_wdata[pwmtg_pkg::CFG_CHIP_LSB +: 5] <= pwmtg_pkg::CHIP_SLOT_F)
                        state_next.chip = i_wdata[pwmtg_pkg::CFG_CHIP_LSB +: 5];
                    if (i_wdata[pwmtg_pkg::CFG_CHAN_LSB +: 2] <= pwmtg_pkg::CHAN_LAST)
                        state_next.chan = i_wdata[pwmtg_pkg::CFG_CHAN_LSB +: 2];
                    state_next.pclk = i_wdata[pwmtg_pkg::CFG_PCLK_LSB +: 3];
                    state_next.tclk = i_wdata[pwmtg_pkg::CFG_TCLK_LSB +: 3];
                    state_next.tgate = i_wdata[pwmtg_pkg::CFG_GATE_LSB +: 2];
                end
                pwmtg_pkg::OFS_DIVISOR:
                    state_next.div = pwmtg_pkg::clamp_count(i_wdata, pwmtg_pkg::DIV_MIN);
                pwmtg_pkg::OFS_LOW_COUNT:
                    state_next.low = pwmtg_pkg::clamp_count(i_wdata, pwmtg_pkg::LOW_MIN);
                default:
                    state_next.run = state_reg.run;
            endcase
        end
        state_next.rdata = '0;
        if (i_rd)
        begin
            case (i_addr)
                pwmtg_pkg::OFS_CTRL:
                    state_next.rdata[pwmtg_pkg::CTRL_RUN_BIT] = state_reg.run;
                pwmtg_pkg::OFS_CONFIG:
                begin
                    state_next.rdata[pwmtg_pkg::CFG_CHIP_LSB +: 5] = state_reg.chip;
                    state_next.rdata[pwmtg_pkg::CFG_CHAN_LSB +: 2] = state_reg.chan;
                    state_next.rdata[pwmtg_pkg::CFG_PCLK_LSB +: 3] = state_reg.pclk;
                    state_next.rdata[pwmtg_pkg::CFG_TCLK_LSB +: 3] = state_reg.tclk;
                    state_next.rdata[pwmtg_pkg::CFG_GATE_LSB +: 2] = state_reg.tgate;
                end
                pwmtg_pkg::OFS_DIVISOR:
                    state_next.rdata[pwmtg_pkg::COUNT_W-1:0] = state_reg.div;
                pwmtg_pkg::OFS_LOW_COUNT:
                    state_next.rdata[pwmtg_pkg::COUNT_W-1:0] = state_reg.low;
                pwmtg_pkg::OFS_STATUS:
                begin
                    state_next.rdata[pwmtg_pkg::ST_PULSE_BIT] = pulse_if.out;
                    state_next.rdata[pwmtg_pkg::ST_TRAIN_BIT] = train_if.out;
                    state_next.rdata[pwmtg_pkg::ST_RUN_BIT] = state_reg.run;
                    state_next.rdata[pwmtg_pkg::ST_TCHIP_LSB +: 5] = train_map[6:2];
                    state_next.rdata[pwmtg_pkg::ST_TCHAN_LSB +: 2] = train_map[1:0];
                end
                default:
                    state_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_reg.run <= pwmtg_pkg::RST_RUN;
            state_reg.chip <= pwmtg_pkg::RST_CHIP;
            state_reg.chan <= pwmtg_pkg::RST_CHAN;
            state_reg.pclk <= pwmtg_pkg::RST_CLK;
            state_reg.tclk <= pwmtg_pkg::RST_CLK;
            state_reg.tgate <= pwmtg_pkg::RST_GATE;
            state_reg.div <= pwmtg_pkg::RST_DIV;
            state_reg.low <= pwmtg_pkg::RST_LOW;
            state_reg.rdata <= '0;
            state_reg.ticks <= '0;
            state_reg.acc <= '0;
            state_reg.sync1 <= '0;
            state_reg.sync2 <= '0;
        end
        else
            state_reg <= state_next;
    end

    assign o_rdata = state_reg.rdata;
    assign o_pulse = pulse_if.out;
    assign o_train = train_if.out;

    property p_pulse_follows_train;
        @(posedge i_clk) disable iff (i_reset)
        (HAS_ROUTING == 1 && state_reg.run && state_reg.low != 17'h00000 && $rose(o_train))
            |=> !o_pulse;
    endproperty
    a_pulse_follows_train: assert property (p_pulse_follows_train) else $error("no trigger");

    property p_train_map;
        @(posedge i_clk) disable iff (i_reset)
        ((train_map[6:2] / 4) * 3 + train_map[1:0] + 2) % 18
            == (state_reg.chip / 4) * 3 + state_reg.chan;
    endproperty
    a_train_map: assert property (p_train_map) else $error("train channel mapping wrong");

    property p_chan_range;
        @(posedge i_clk) disable iff (i_reset)
        state_reg.chan <= pwmtg_pkg::CHAN_LAST;
    endproperty
    a_chan_range: assert property (p_chan_range) else $error("pulse channel out of range");

    property p_chip_grid;
        @(posedge i_clk) disable iff (i_reset)
        state_reg.chip[1:0] == 2'h0 && state_reg.chip <= pwmtg_pkg::CHIP_SLOT_F;
    endproperty
    a_chip_grid: assert property (p_chip_grid) else $error("chip offset off grid");

    property p_fast_tick;
        @(posedge i_clk) disable iff (i_reset)
        state_reg.ticks[0] |=> !state_reg.ticks[0];
    endproperty
    a_fast_tick: assert property (p_fast_tick) else $error("fast tick too dense");

    property p_gate_low;
        @(posedge i_clk) disable iff (i_reset)
        (HAS_ROUTING == 1 && state_reg.tgate == pwmtg_pkg::GATE_FORCE_LOW) |=> o_train;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("train ran with gate low");

    property p_div_limits;
        @(posedge i_clk) disable iff (i_reset)
        (i_wr && i_addr == pwmtg_pkg::OFS_DIVISOR)
            |=> (state_reg.div >= 17'h00002 && state_reg.div <= 17'h10000);
    endproperty
    a_div_limits: assert property (p_div_limits) else $error("divisor outside limits");

    property p_low_limit;
        @(posedge i_clk) disable iff (i_reset)
        (i_wr && i_addr == pwmtg_pkg::OFS_LOW_COUNT) |=> state_reg.low <= 17'h10000;
    endproperty
    a_low_limit: assert property (p_low_limit) else $error("low count above limit");

    property p_stop_pulse;
        @(posedge i_clk) disable iff (i_reset)
        !state_reg.run |=> o_pulse;
    endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("pulse low while stopped");

    property p_stop_write;
        @(posedge i_clk) disable iff (i_reset)
        (i_wr && i_addr == pwmtg_pkg::OFS_CTRL && !i_wdata[pwmtg_pkg::CTRL_RUN_BIT])
            |=> ##1 o_pulse;
    endproperty
    a_stop_write: assert property (p_stop_write) else $error("stop write left pulse low");

    property p_low_zero;
        @(posedge i_clk) disable iff (i_reset)
        (state_reg.low == pwmtg_pkg::LOW_MIN && o_pulse) |=> o_pulse;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("zero low count drove pulse low");

    property p_bare_gate;
        @(posedge i_clk) disable iff (i_reset)
        (HAS_ROUTING == 0 && !state_reg.sync2[0]) |=> o_train;
    endproperty
    a_bare_gate: assert property (p_bare_gate) else $error("train ran with pin gate low");

    property p_bare_trigger;
        @(posedge i_clk) disable iff (i_reset)
        (HAS_ROUTING == 0 && state_reg.run && state_reg.low != 17'h00000
            && state_reg.sync2[2] && !$past(state_reg.sync2[2])) |=> !o_pulse;
    endproperty
    a_bare_trigger: assert property (p_bare_trigger) else $error("pin trigger ignored");

    c_pulse_low: cover property (@(posedge i_clk) disable iff (i_reset) $fell(o_pulse));
    c_stop: cover property (@(posedge i_clk) disable iff (i_reset) $fell(state_reg.run));
    c_status_read: cover property (@(posedge i_clk) disable iff (i_reset)
        i_rd && i_addr == pwmtg_pkg::OFS_STATUS);
endmodule

// file: src/pwmtg_pkg.sv
package pwmtg_pkg;
    localparam int ACC_W = 26;
    localparam int NUM_SRC = 5;
    localparam int COUNT_W = 17;
    // System clock rate: 25 MHz, 40 ns period
    localparam logic [ACC_W-1:0] SYS_CLK_HZ = 26'h17D7840;
    localparam logic [ACC_W-1:0] FREQ_TEN_MEG = 26'h0989680;
    localparam logic [ACC_W-1:0] FREQ_ONE_MEG = 26'h00F4240;
    localparam logic [ACC_W-1:0] FREQ_HUNDRED_KILO = 26'h00186A0;
    localparam logic [ACC_W-1:0] FREQ_TEN_KILO = 26'h0002710;
    localparam logic [ACC_W-1:0] FREQ_ONE_KILO = 26'h00003E8;

    localparam logic [2:0] CLK_SEL_TEN_MEG = 3'h1;
    localparam logic [2:0] CLK_SEL_ONE_MEG = 3'h2;
    localparam logic [2:0] CLK_SEL_HUNDRED_KILO = 3'h3;
    localparam logic [2:0] CLK_SEL_TEN_KILO = 3'h4;
    localparam logic [2:0] CLK_SEL_ONE_KILO = 3'h5;

    localparam logic [1:0] GATE_FORCE_HIGH = 2'h0;
    localparam logic [1:0] GATE_FORCE_LOW = 2'h1;
    localparam logic [1:0] GATE_EXTERNAL_INPUT = 2'h2;
    localparam logic [1:0] GATE_INVERTED_LOWER_OUTPUT = 2'h3;

    localparam logic [4:0] CHIP_SLOT_A = 5'h00;
    localparam logic [4:0] CHIP_SLOT_B = 5'h04;
    localparam logic [4:0] CHIP_SLOT_C = 5'h08;
    localparam logic [4:0] CHIP_SLOT_D = 5'h0C;
    localparam logic [4:0] CHIP_SLOT_E = 5'h10;
    localparam logic [4:0] CHIP_SLOT_F = 5'h14;
    localparam logic [4:0] CHIP_SPACING = 5'h04;
    localparam logic [1:0] CHAN_LAST = 2'h2;
    localparam logic [1:0] TRAIN_CHAN_STEP = 2'h2;

    localparam logic [COUNT_W-1:0] COUNT_MAX = 17'h10000;
    localparam logic [COUNT_W-1:0] DIV_MIN = 17'h00002;
    localparam logic [COUNT_W-1:0] LOW_MIN = 17'h00000;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_DIVISOR = 8'h08;
    localparam logic [7:0] OFS_LOW_COUNT = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CFG_CHIP_LSB = 0;
    localparam int CFG_CHAN_LSB = 8;
    localparam int CFG_PCLK_LSB = 12;
    localparam int CFG_TCLK_LSB = 16;
    localparam int CFG_GATE_LSB = 20;
    localparam int ST_PULSE_BIT = 0;
    localparam int ST_TRAIN_BIT = 1;
    localparam int ST_RUN_BIT = 2;
    localparam int ST_TCHIP_LSB = 8;
    localparam int ST_TCHAN_LSB = 16;

    localparam logic RST_RUN = 1'b0;
    localparam logic [4:0] RST_CHIP = CHIP_SLOT_B;
    localparam logic [1:0] RST_CHAN = 2'h0;
    localparam logic [2:0] RST_CLK = CLK_SEL_ONE_MEG;
    localparam logic [1:0] RST_GATE = GATE_FORCE_HIGH;
    localparam logic [COUNT_W-1:0] RST_DIV = 17'h0000A;
    localparam logic [COUNT_W-1:0] RST_LOW = 17'h00005;

    function automatic logic [ACC_W-1:0] source_rate(input int idx);
        case (idx)
            0: return FREQ_TEN_MEG;
            1: return FREQ_ONE_MEG;
            2: return FREQ_HUNDRED_KILO;
            3: return FREQ_TEN_KILO;
            default: return FREQ_ONE_KILO;
        endcase
    endfunction

    // Returns {train chip offset, train channel}: two channels below, wrapping
    function automatic logic [6:0] train_of(input logic [4:0] chip, input logic [1:0] chan);
        logic [4:0] tchip;
        tchip = (chip == CHIP_SLOT_A) ? CHIP_SLOT_F : chip - CHIP_SPACING;
        if (chan == CHAN_LAST)
            return {chip, chan - TRAIN_CHAN_STEP};
        else
            return {tchip, chan + 2'h1};
    endfunction

    function automatic logic [COUNT_W-1:0] clamp_count(input logic [31:0] v,
                                                      input logic [COUNT_W-1:0] lo);
        if (v < {15'h0000, lo})
            return lo;
        else if (v > {15'h0000, COUNT_MAX})
            return COUNT_MAX;
        else
            return v[COUNT_W-1:0];
    endfunction
endpackage

// file: src/pwmtg_chan_if.sv
`timescale 1ns/1ns
interface pwmtg_chan_if;
    logic tick;
    logic gate;
    logic oneshot;
    logic enable;
    logic [pwmtg_pkg::COUNT_W-1:0] load;
    logic out;
    logic [pwmtg_pkg::COUNT_W-1:0] count;
    modport ctl (output tick, output gate, output oneshot, output enable, output load,
                 input out, input count);
    modport chan (input tick, input gate, input oneshot, input enable, input load,
                  output out, output count);
endinterface

// file: src/pwmtg_chan.sv
`timescale 1ns/1ns
module pwmtg_chan (
    input wire logic i_clk,
    input wire logic i_reset,
    pwmtg_chan_if.chan ch
);
    typedef struct packed {
        logic [pwmtg_pkg::COUNT_W-1:0] count;
        logic out;
        logic gate_prev;
    } pwmtg_chan_state_type;

    pwmtg_chan_state_type state_reg;
    pwmtg_chan_state_type state_next;
    logic gate_rise;

    assign gate_rise = ch.gate && !state_reg.gate_prev;
    assign ch.out = state_reg.out;
    assign ch.count = state_reg.count;

    always_comb
    begin
        state_next = state_reg;
        state_next.gate_prev = ch.gate;
        if (ch.oneshot)
        begin
            if (!ch.enable)
            begin
                state_next.out = 1'b1;
                state_next.count = '0;
            end
            else if (gate_rise)
            begin
                // Retrigger mid-count restarts the low time
                state_next.out = (ch.load == pwmtg_pkg::LOW_MIN);
                state_next.count = ch.load;
            end
            else if (ch.tick && !state_reg.out)
            begin
                if (state_reg.count <= 17'h00001)
                begin
                    state_next.out = 1'b1;
                    state_next.count = '0;
                end
                else
                    state_next.count = state_reg.count - 17'h00001;
            end
        end
        else
        begin
            if (!ch.gate)
                state_next.out = 1'b1;
            else if (gate_rise)
            begin
                state_next.out = 1'b1;
                state_next.count = ch.load;
            end
            else if (ch.tick)
            begin
                // Low for one source period, so period equals the divisor
                if (state_reg.count <= 17'h00001)
                begin
                    state_next.out = 1'b0;
                    state_next.count = ch.load;
                end
                else
                begin
                    state_next.out = 1'b1;
                    state_next.count = state_reg.count - 17'h00001;
                end
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_reg.count <= '0;
            state_reg.out <= 1'b1;
            state_reg.gate_prev <= 1'b0;
        end
        else
            state_reg <= state_next;
    end

    property p_stop_high;
        @(posedge i_clk) disable iff (i_reset)
        (ch.oneshot && !ch.enable) |=> state_reg.out;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stopped one-shot not high");

    property p_trigger_low;
        @(posedge i_clk) disable iff (i_reset)
        (ch.oneshot && ch.enable && gate_rise && ch.load != 17'h00000)
            |=> (!state_reg.out && state_reg.count == $past(ch.load));
    endproperty
    a_trigger_low: assert property (p_trigger_low) else $error("trigger did not restart");

    property p_rate_reload;
        @(posedge i_clk) disable iff (i_reset)
        (!ch.oneshot && ch.gate && !gate_rise && ch.tick && state_reg.count <= 17'h00001)
            |=> (!state_reg.out && state_reg.count == $past(ch.load));
    endproperty
    a_rate_reload: assert property (p_rate_reload) else $error("rate reload wrong");

    c_retrigger: cover property (@(posedge i_clk) disable iff (i_reset)
        ch.oneshot && ch.enable && gate_rise && !state_reg.out);
    c_reload: cover property (@(posedge i_clk) disable iff (i_reset)
        !ch.oneshot && !state_reg.out);
endmodule

// file: dv/pwmtg_load_model.sv
`timescale 1ns/1ns
// Equipment on the pulse output: times each low pulse and each fall-to-fall period
module pwmtg_load_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_pulse,
    output logic [31:0] o_low_len,
    output logic [31:0] o_period,
    output logic [15:0] o_falls
);
    logic [31:0] low_cnt;
    logic [31:0] per_cnt;
    logic last;
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            {low_cnt, per_cnt, o_low_len, o_period, o_falls} <= '0;
            last <= 1'b1;
        end
        else
        begin
            last <= i_pulse;
            per_cnt <= per_cnt + 32'h1;
            low_cnt <= low_cnt + 32'h1;
            if (last && !i_pulse)
            begin
                o_period <= per_cnt;
                per_cnt <= 32'h1;
                low_cnt <= 32'h1;
                o_falls <= o_falls + 16'h1;
            end
            if (!last && i_pulse)
                o_low_len <= low_cnt;
        end
    end
endmodule

// file: dv/pwmtg_top_tb.sv
`timescale 1ns/1ns
module pwmtg_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext = 1'b0;
    logic lo_out = 1'b0;
    logic rd_dly = 1'b0;
    logic [31:0] rdata, low_len, period;
    logic pulse, train, pulse2, train2;
    logic [15:0] falls, falls2;
    logic [63:0] expq[$];
    int errors = 0;
    int compares = 0;

    pwmtg_top #(.HAS_ROUTING(1)) dut (.i_clk(clk), .i_reset(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_ext_gate(ext), .i_lower_out(lo_out),
        .i_pulse_gate(1'b0), .o_rdata(rdata), .o_pulse(pulse), .o_train(train));
    pwmtg_load_model load (.i_clk(clk), .i_reset(rst), .i_pulse(pulse),
        .o_low_len(low_len), .o_period(period), .o_falls(falls));
    // Routing-free build: outside wiring feeds its train output to its pulse gate
    pwmtg_top #(.HAS_ROUTING(0)) dut_wired (.i_clk(clk), .i_reset(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_ext_gate(ext), .i_lower_out(lo_out),
        .i_pulse_gate(train2), .o_rdata(), .o_pulse(pulse2), .o_train(train2));
    pwmtg_load_model load2 (.i_clk(clk), .i_reset(rst), .i_pulse(pulse2),
        .o_low_len(), .o_period(), .o_falls(falls2));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic inr(input logic [31:0] v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd32(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        expq.push_back({m, e});
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Three falls, so the measured period starts after any reload from older settings
    task automatic meas(input int lim);
        int f0;
        f0 = falls;
        for (int i = 0; i < lim && falls - f0 < 3; i++)
            @(posedge clk);
        if (falls - f0 < 3)
        begin
            errors++;
            end_sim();
        end
    endtask
    task automatic window(input int n, output int hi, output int fl);
        int f0;
        f0 = falls;
        hi = 0;
        repeat (n)
        begin
            @(posedge clk);
            hi += (pulse === 1'b1);
        end
        fl = falls - f0;
    endtask
    function automatic logic [31:0] cfg(input logic [4:0] chip, input logic [1:0] ch,
        input logic [2:0] pc, input logic [2:0] tc, input logic [1:0] g);
        return {10'h0, g, 1'b0, tc, 1'b0, pc, 2'h0, ch, 3'h0, chip};
    endfunction

    always @(posedge clk)
    begin
        rd_dly <= rd;
        if (rd_dly && expq.size() > 0)
        begin
            chk(rdata & expq[0][63:32], expq[0][31:0]);
            void'(expq.pop_front());
        end
    end

    initial
    begin
        forever #20 clk = ~clk;
    end

    initial
    begin
        logic [4:0] tchip;
        int d, hi, fl, f2;
        void'($urandom(7));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd32(8'h04, 32'h0037731F, 32'h00022004);
        rd32(8'h08, 32'h0001FFFF, 32'h0000000A);
        rd32(8'h0C, 32'h0001FFFF, 32'h00000005);
        rd32(8'h10, 32'h00031F04, 32'h00010000);
        wr32(8'h20, 32'hFFFFFFFF);
        rd32(8'h20, 32'hFFFFFFFF, 32'h00000000);
        for (int c = 0; c < 6; c++)
            for (int n = 0; n < 3; n++)
            begin
                wr32(8'h04, cfg(5'(c * 4), 2'(n), 3'h1, 3'h1, 2'h0));
                tchip = (n == 2) ? 5'(c * 4) : (c == 0 ? 5'h14 : 5'(c * 4 - 4));
                rd32(8'h10, 32'h00031F00, {14'h0, 2'(n == 2 ? 0 : n + 1), 3'h0, tchip, 8'h0});
            end
        wr32(8'h04, cfg(5'h06, 2'h0, 3'h1, 3'h1, 2'h0));
        rd32(8'h10, 32'h00031F00, 32'h00011000);
        wr32(8'h04, cfg(5'h00, 2'h3, 3'h1, 3'h1, 2'h0));
        rd32(8'h10, 32'h00031F00, 32'h00011400);
        wr32(8'h08, 32'h00000001);
        rd32(8'h08, 32'h0001FFFF, 32'h00000002);
        wr32(8'h08, 32'h0001FFFF);
        rd32(8'h08, 32'h0001FFFF, 32'h00010000);
        wr32(8'h0C, 32'h0001FFFF);
        rd32(8'h0C, 32'h0001FFFF, 32'h00010000);
        wr32(8'h00, 32'h00000001);
        rd32(8'h10, 32'h00000004, 32'h00000004);
        wr32(8'h0C, 32'h00000001);
        for (int k = 0; k < 5; k++)
        begin
            d = (k == 0) ? 2 : 2 + $urandom % 30;
            wr32(8'h08, 32'(d));
            meas(d * 10 + 200);
            inr(period, d * 5 / 2 - 1, (d * 5 + 1) / 2 + 1);
        end
        // Same code on both channels; 1 kHz left out to keep the run short
        wr32(8'h08, 32'h00000004);
        wr32(8'h0C, 32'h00000002);
        for (int k = 1; k < 5; k++)
        begin
            wr32(8'h04, cfg(5'h0, 2'h0, 3'(k), 3'(k), 2'h0));
            d = 5 * 10 ** (k - 1);
            meas(d * 8 + 100);
            inr(period, d * 2 - 1, d * 2 + 1);
            inr(low_len, d / 2 - 1, d + 1);
        end
        wr32(8'h04, cfg(5'h0, 2'h0, 3'h2, 3'h1, 2'h0));
        wr32(8'h0C, 32'h00000004);
        repeat (300) @(posedge clk);
        window(200, hi, fl);
        chk(32'(hi), 32'h0);
        wr32(8'h00, 32'h00000000);
        @(posedge clk);
        #1;
        chk({31'h0, pulse}, 32'h1);
        window(200, hi, fl);
        chk(32'(hi + fl * 1000), 32'd200);
        wr32(8'h00, 32'h00000001);
        repeat (300) @(posedge clk);
        window(200, hi, fl);
        chk(32'(hi), 32'h0);
        wr32(8'h0C, 32'h00000001);
        for (int k = 0; k < 6; k++)
        begin
            ext <= k == 3;
            lo_out <= k == 4;
            wr32(8'h04, cfg(5'h0, 2'h0, 3'h1, 3'h1, 2'(k < 2 ? k : (k < 4 ? 2 : 3))));
            repeat (30) @(posedge clk);
            f2 = falls2;
            window(100, hi, fl);
            chk(32'(fl > 0), 32'(k == 0 || k == 3 || k == 5));
            chk(32'(falls2 != f2), 32'(k == 3));
        end
        wr32(8'h0C, 32'h00000000);
        repeat (30) @(posedge clk);
        window(100, hi, fl);
        chk(32'(hi), 32'd100);
        end_sim();
    end
endmodule
